// ===== pbmc_map.vh
// Register map, field positions, reset values and timing constants of the mode control bank.
`ifndef PBMC_MAP_VH
`define PBMC_MAP_VH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define PBMC_ADDR_W        5
`define PBMC_DATA_W        16

// ****************************************************************
// Register offsets
// ****************************************************************
`define PBMC_OFS_BMC       5'h00
`define PBMC_OFS_IRQ_STAT  5'h10
`define PBMC_OFS_IRQ_MASK  5'h11
`define PBMC_OFS_EVT       5'h14
`define PBMC_OFS_PSF       5'h18
`define PBMC_OFS_LQD       5'h1e
`define PBMC_OFS_LQM2      5'h1f

// ****************************************************************
// Basic mode control fields
// ****************************************************************
`define PBMC_B_SRST        15
`define PBMC_B_LOOP        14
`define PBMC_B_SPEED       13
`define PBMC_B_ANEG        12
`define PBMC_B_PDOWN       11
`define PBMC_B_ISO         10
`define PBMC_B_RESTART     9
`define PBMC_B_DUPLEX      8
`define PBMC_B_COLT        7
`define PBMC_B_UNIDIR      5

// ****************************************************************
// Writable masks of the map-only registers
// ****************************************************************
`define PBMC_MASK_PSF      16'h1ff8
`define PBMC_MASK_LQD      16'h3fff
`define PBMC_MASK_LQM2     16'h0402
`define PBMC_RST_WORD      16'h0000

// ****************************************************************
// Event status register fields
// ****************************************************************
`define PBMC_E_LINK_LL     0
`define PBMC_E_FAULT_LH    1
`define PBMC_E_RXERR_COR   2
`define PBMC_E_ACTIVE_SC   3
`define PBMC_E_PERM_LO     12
`define PBMC_E_PERM_HI     15
`define PBMC_E_PERM_VAL    4'ha

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define PBMC_IRQ_W         5
`define PBMC_I_SRST_DONE   0
`define PBMC_I_AN_STARTED  1
`define PBMC_I_PIN_PDOWN   2
`define PBMC_I_LOOP_READY  3
`define PBMC_I_FAULT       4

// ****************************************************************
// Pin synchroniser lanes
// ****************************************************************
`define PBMC_PIN_W         5
`define PBMC_P_PDOWN_N     0
`define PBMC_P_ANEG        1
`define PBMC_P_SPEED       2
`define PBMC_P_DUPLEX      3
`define PBMC_P_FIBER       4
`define PBMC_PIN_RST       5'h01

// ****************************************************************
// Timing
// ****************************************************************
`define PBMC_CLK_MHZ       40
`define PBMC_SRST_TIME_NS  2000
`define PBMC_SRST_CYC      ((`PBMC_SRST_TIME_NS * `PBMC_CLK_MHZ + 999) / 1000)
`define PBMC_LOOP_DEAD_US  500
`define PBMC_LOOP_DEAD_CYC (`PBMC_LOOP_DEAD_US * `PBMC_CLK_MHZ)

`endif

// ===== pbmc_pin_sync.v
// Three-stage pin synchroniser whose filtered output moves only when stages two and three agree.
`timescale 1ns/100ps
`default_nettype none

module pbmc_pin_sync #(
  parameter             W       = 1,
  parameter [W-1:0]     RST_VAL = {W{1'b0}}
) (
  // Clock and control
  input  wire           i_clk,
  input  wire           i_srst,
  input  wire           i_ce,
  // Pins and filtered result
  input  wire [W-1:0]   i_pin,
  output reg  [W-1:0]   o_filt
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer     k;

  // The first stage feeds only the second, so metastability never reaches a comparator.
  always @(posedge i_clk) begin
    if (i_srst) begin
      s1_r   <= RST_VAL;
      s2_r   <= RST_VAL;
      s3_r   <= RST_VAL;
      o_filt <= RST_VAL;
    end else if (i_ce) begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (k = 0; k < W; k = k + 1) begin
        if (s2_r[k] == s3_r[k]) begin
          o_filt[k] <= s3_r[k];
        end
      end
    end
  end

endmodule // pbmc_pin_sync

`default_nettype wire

// ===== pbmc_top.v
// Basic mode control register bank of a 10/100 transceiver with its access-type conventions.
// Functional notes
// - Writing one to bit 15 starts soft reset; reads one until done, then clears.
// - Soft reset reloads strap-derived configuration into strap-controlled bits.
// - Loopback bit routes MAC transmit data back into MAC receive path.
// - After loopback is set, receive data is withheld for up to 500 us.
// - With negotiation off, speed bit one gives 100 Mb/s, zero 10 Mb/s.
// - Negotiation enabled ignores speed and duplex bits; disabled, they set the port.
// - Negotiation enable takes its reset value from its strap input.
// - Fiber mode forces negotiation enable to zero at reset.
// - Power down bit powers down the port; register access keeps working.
// - Effective power down is bit OR active-low pin; pin assertion sets bit.
// - Isolate bit disconnects MAC data interface; management keeps working.
// - Clear-on-read bits return to inactive value when read.
// - Latched-low bits drop on event and stay low until read.
// - Latched-high bits rise on event and stay high until read.
// - Self-clearing bits set during event and clear when it ends.
// - Permanent read-only bits return fixed value; writes have no effect.
// - With negotiation off, duplex bit one gives full, zero half duplex.
// - Restart bit restarts negotiation if enabled; reads one until negotiation begins.
`timescale 1ns/100ps
`default_nettype none
`include "pbmc_map.vh"

module pbmc_top #(
  parameter             LOOP_DEAD_CYCLES = `PBMC_LOOP_DEAD_CYC,
  parameter             DEAD_W           = 15,
  parameter             SRST_W           = 8,
  parameter             NIB_W            = 4
) (
  // Clock, reset and clock enable
  input  wire                     i_clk,
  input  wire                     i_srst,
  input  wire                     i_ce,
  // Register port
  input  wire [`PBMC_ADDR_W-1:0]  i_addr,
  input  wire [`PBMC_DATA_W-1:0]  i_wdata,
  input  wire                     i_wr,
  input  wire                     i_rd,
  output reg  [`PBMC_DATA_W-1:0]  o_rdata,
  // Pins and straps
  input  wire                     i_power_down_pin_n,
  input  wire                     i_strap_aneg,
  input  wire                     i_strap_speed_100,
  input  wire                     i_strap_full_duplex,
  input  wire                     i_fiber_mode_enable,
  // Negotiation engine
  input  wire                     i_an_speed_100,
  input  wire                     i_an_full_duplex,
  input  wire                     i_aneg_started,
  // Event sources
  input  wire                     i_link_ok,
  input  wire                     i_fault,
  input  wire                     i_rx_err,
  input  wire                     i_event_active,
  // MAC side data
  input  wire                     i_mac_tx_en,
  input  wire [NIB_W-1:0]         i_mac_txd,
  output reg                      o_mac_rx_dv,
  output reg  [NIB_W-1:0]         o_mac_rxd,
  output reg                      o_mac_col,
  // Line side data
  input  wire                     i_line_rx_dv,
  input  wire [NIB_W-1:0]         i_line_rxd,
  output reg                      o_line_tx_en,
  output reg  [NIB_W-1:0]         o_line_txd,
  // Mode outputs
  output reg                      o_speed_100,
  output reg                      o_full_duplex,
  output reg                      o_aneg_enable,
  output reg                      o_aneg_restart,
  output reg                      o_loopback,
  output reg                      o_loop_dead,
  output reg                      o_power_down,
  output reg                      o_isolate,
  output reg                      o_unidirectional,
  output reg                      o_core_reset,
  output reg                      o_irq
);

  // ****************************************************************
  // Constants and helpers
  // ****************************************************************
  // Integer sums are cut to the counter widths on purpose; both values fit.
  localparam integer      SRST_LAST_I = `PBMC_SRST_CYC - 1;
  localparam [SRST_W-1:0] SRST_LAST   = SRST_LAST_I[SRST_W-1:0];
  localparam [DEAD_W-1:0] DEAD_LOAD   = LOOP_DEAD_CYCLES[DEAD_W-1:0];
  localparam [DEAD_W-1:0] DEAD_ONE    = {{(DEAD_W-1){1'b0}}, 1'b1};
  localparam [SRST_W-1:0] SRST_ONE    = {{(SRST_W-1){1'b0}}, 1'b1};

  // Sticky flag update where a hardware set beats a clear in the same cycle.
  function set_wins;
    input old_v;
    input set_v;
    input clr_v;
    begin
      set_wins = set_v | (old_v & ~clr_v);
    end
  endfunction

  // Address match qualified by a strobe.
  function hit;
    input [`PBMC_ADDR_W-1:0] a;
    input [`PBMC_ADDR_W-1:0] ofs;
    input                    stb;
    begin
      hit = stb & (a == ofs);
    end
  endfunction

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  wire [`PBMC_PIN_W-1:0] pins_filt;

  pbmc_pin_sync #(
    .W       (`PBMC_PIN_W),
    .RST_VAL (`PBMC_PIN_RST)
  ) u_pin_sync (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_ce   (i_ce),
    .i_pin  ({i_fiber_mode_enable, i_strap_full_duplex, i_strap_speed_100,
              i_strap_aneg, i_power_down_pin_n}),
    .o_filt (pins_filt)
  );

  wire pin_pdown = ~pins_filt[`PBMC_P_PDOWN_N];

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg                    loop_r;
  reg                    speed_r;
  reg                    aneg_r;
  reg                    pdown_r;
  reg                    iso_r;
  reg                    restart_r;
  reg                    duplex_r;
  reg                    colt_r;
  reg                    unidir_r;
  reg                    srst_busy_r;
  reg [SRST_W-1:0]       srst_cnt_r;
  reg [DEAD_W-1:0]       dead_cnt_r;
  reg [`PBMC_DATA_W-1:0] psf_r;
  reg [`PBMC_DATA_W-1:0] lqd_r;
  reg [`PBMC_DATA_W-1:0] lqm2_r;
  reg                    evt_ll_r;
  reg                    evt_lh_r;
  reg                    evt_cor_r;
  reg                    evt_sc_r;
  reg [`PBMC_IRQ_W-1:0]  irq_stat_r;
  reg [`PBMC_IRQ_W-1:0]  irq_mask_r;
  reg [`PBMC_IRQ_W-1:0]  irq_set;

  wire wr_bmc   = hit(i_addr, `PBMC_OFS_BMC, i_wr);
  wire rd_evt   = hit(i_addr, `PBMC_OFS_EVT, i_rd);
  wire srst_end = srst_busy_r & (srst_cnt_r == {SRST_W{1'b0}});
  wire pd_eff   = pdown_r | pin_pdown;

  // Assembled views used by the read mux; unused positions stay zero.
  reg [`PBMC_DATA_W-1:0] bmc_view;
  reg [`PBMC_DATA_W-1:0] evt_view;

  always @* begin
    bmc_view                      = `PBMC_RST_WORD;
    bmc_view[`PBMC_B_SRST]        = srst_busy_r;
    bmc_view[`PBMC_B_LOOP]        = loop_r;
    bmc_view[`PBMC_B_SPEED]       = speed_r;
    bmc_view[`PBMC_B_ANEG]        = aneg_r;
    bmc_view[`PBMC_B_PDOWN]       = pdown_r;
    bmc_view[`PBMC_B_ISO]         = iso_r;
    bmc_view[`PBMC_B_RESTART]     = restart_r;
    bmc_view[`PBMC_B_DUPLEX]      = duplex_r;
    bmc_view[`PBMC_B_COLT]        = colt_r;
    bmc_view[`PBMC_B_UNIDIR]      = unidir_r;
    evt_view                      = `PBMC_RST_WORD;
    evt_view[`PBMC_E_LINK_LL]     = evt_ll_r;
    evt_view[`PBMC_E_FAULT_LH]    = evt_lh_r;
    evt_view[`PBMC_E_RXERR_COR]   = evt_cor_r;
    evt_view[`PBMC_E_ACTIVE_SC]   = evt_sc_r;
    evt_view[`PBMC_E_PERM_HI:`PBMC_E_PERM_LO] = `PBMC_E_PERM_VAL;
  end

  // ****************************************************************
  // Soft reset sequencer
  // ****************************************************************
  // Hardware reset also runs the sequencer, so straps are caught only after the
  // synchroniser has filled rather than from the raw pins under reset.
  always @(posedge i_clk) begin
    if (i_srst) begin
      srst_busy_r <= 1'b1;
      srst_cnt_r  <= SRST_LAST;
    end else if (i_ce) begin
      if (srst_busy_r) begin
        if (srst_end) begin
          srst_busy_r <= 1'b0;
        end else begin
          srst_cnt_r <= srst_cnt_r - SRST_ONE;
        end
      end else if (wr_bmc && i_wdata[`PBMC_B_SRST]) begin
        srst_busy_r <= 1'b1;
        srst_cnt_r  <= SRST_LAST;
      end
    end
  end

  // ****************************************************************
  // Basic mode control fields
  // ****************************************************************
  // Writes are ignored while the sequencer runs; the reload at its end would
  // overwrite them anyway and a half-applied mode is worse than none.
  always @(posedge i_clk) begin
    if (i_srst) begin
      loop_r    <= 1'b0;
      speed_r   <= 1'b0;
      aneg_r    <= 1'b0;
      pdown_r   <= 1'b0;
      iso_r     <= 1'b0;
      restart_r <= 1'b0;
      duplex_r  <= 1'b0;
      colt_r    <= 1'b0;
      unidir_r  <= 1'b0;
    end else if (i_ce) begin
      if (srst_end) begin
        loop_r    <= 1'b0;
        speed_r   <= pins_filt[`PBMC_P_SPEED];
        duplex_r  <= pins_filt[`PBMC_P_DUPLEX];
        aneg_r    <= pins_filt[`PBMC_P_ANEG]
                     & ~pins_filt[`PBMC_P_FIBER];
        pdown_r   <= pin_pdown;
        iso_r     <= 1'b0;
        restart_r <= 1'b0;
        colt_r    <= 1'b0;
        unidir_r  <= 1'b0;
      end else if (wr_bmc && !srst_busy_r && !i_wdata[`PBMC_B_SRST]) begin
        loop_r    <= i_wdata[`PBMC_B_LOOP];
        speed_r   <= i_wdata[`PBMC_B_SPEED];
        aneg_r    <= i_wdata[`PBMC_B_ANEG];
        pdown_r   <= i_wdata[`PBMC_B_PDOWN] | pin_pdown;
        iso_r     <= i_wdata[`PBMC_B_ISO];
        duplex_r  <= i_wdata[`PBMC_B_DUPLEX];
        colt_r    <= i_wdata[`PBMC_B_COLT];
        unidir_r  <= i_wdata[`PBMC_B_UNIDIR];
        // A restart request beats a same-cycle acknowledge.
        restart_r <= set_wins(restart_r,
                              i_wdata[`PBMC_B_RESTART] & i_wdata[`PBMC_B_ANEG],
                              i_aneg_started);
      end else begin
        if (pin_pdown) begin
          pdown_r <= 1'b1;
        end
        if (i_aneg_started) begin
          restart_r <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Loopback dead time
  // ****************************************************************
  // The counter restarts only on a rising loopback bit, so rewriting the same
  // value does not stall receive data again.
  always @(posedge i_clk) begin
    if (i_srst) begin
      dead_cnt_r <= {DEAD_W{1'b0}};
    end else if (i_ce) begin
      if (srst_end || !loop_r) begin
        dead_cnt_r <= {DEAD_W{1'b0}};
        if (!srst_end && wr_bmc && !srst_busy_r && !i_wdata[`PBMC_B_SRST]
            && i_wdata[`PBMC_B_LOOP]) begin
          dead_cnt_r <= DEAD_LOAD;
        end
      end else if (dead_cnt_r != {DEAD_W{1'b0}}) begin
        dead_cnt_r <= dead_cnt_r - DEAD_ONE;
      end
    end
  end

  // ****************************************************************
  // Map-only registers
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_srst) begin
      psf_r  <= `PBMC_RST_WORD;
      lqd_r  <= `PBMC_RST_WORD;
      lqm2_r <= `PBMC_RST_WORD;
    end else if (i_ce) begin
      if (hit(i_addr, `PBMC_OFS_PSF, i_wr)) begin
        psf_r <= i_wdata & `PBMC_MASK_PSF;
      end
      if (hit(i_addr, `PBMC_OFS_LQD, i_wr)) begin
        lqd_r <= i_wdata & `PBMC_MASK_LQD;
      end
      if (hit(i_addr, `PBMC_OFS_LQM2, i_wr)) begin
        lqm2_r <= i_wdata & `PBMC_MASK_LQM2;
      end
    end
  end

  // ****************************************************************
  // Event status bits of each access type
  // ****************************************************************
  // A read returns the value before its clear; an event in the read cycle
  // is kept for the next read.
  always @(posedge i_clk) begin
    if (i_srst) begin
      evt_ll_r  <= 1'b1;
      evt_lh_r  <= 1'b0;
      evt_cor_r <= 1'b0;
      evt_sc_r  <= 1'b0;
    end else if (i_ce) begin
      evt_ll_r  <= (rd_evt | evt_ll_r) & i_link_ok;
      evt_lh_r  <= set_wins(evt_lh_r, i_fault, rd_evt);
      evt_cor_r <= set_wins(evt_cor_r, i_rx_err, rd_evt);
      evt_sc_r  <= i_event_active;
    end
  end

  // ****************************************************************
  // Interrupt status, mask and output
  // ****************************************************************
  always @* begin
    irq_set                     = {`PBMC_IRQ_W{1'b0}};
    irq_set[`PBMC_I_SRST_DONE]  = srst_end;
    irq_set[`PBMC_I_AN_STARTED] = restart_r & i_aneg_started;
    irq_set[`PBMC_I_PIN_PDOWN]  = pin_pdown & ~pdown_r;
    irq_set[`PBMC_I_LOOP_READY] = loop_r & (dead_cnt_r == DEAD_ONE);
    irq_set[`PBMC_I_FAULT]      = i_fault & ~evt_lh_r;
  end

  // Write-one-to-clear; a set in the same cycle wins.
  always @(posedge i_clk) begin : irq_regs
    integer n;
    if (i_srst) begin
      irq_stat_r <= {`PBMC_IRQ_W{1'b0}};
      irq_mask_r <= {`PBMC_IRQ_W{1'b0}};
      o_irq      <= 1'b0;
    end else if (i_ce) begin
      for (n = 0; n < `PBMC_IRQ_W; n = n + 1) begin
        irq_stat_r[n] <= set_wins(irq_stat_r[n], irq_set[n],
                                  hit(i_addr, `PBMC_OFS_IRQ_STAT, i_wr) & i_wdata[n]);
      end
      if (hit(i_addr, `PBMC_OFS_IRQ_MASK, i_wr)) begin
        irq_mask_r <= i_wdata[`PBMC_IRQ_W-1:0];
      end
      o_irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Data stand for exactly one cycle after the strobe; unmapped reads return zero.
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= `PBMC_RST_WORD;
    end else if (i_ce) begin
      o_rdata <= `PBMC_RST_WORD;
      if (i_rd) begin
        case (i_addr)
          `PBMC_OFS_BMC:      o_rdata <= bmc_view;
          `PBMC_OFS_EVT:      o_rdata <= evt_view;
          `PBMC_OFS_PSF:      o_rdata <= psf_r;
          `PBMC_OFS_LQD:      o_rdata <= lqd_r;
          `PBMC_OFS_LQM2:     o_rdata <= lqm2_r;
          `PBMC_OFS_IRQ_STAT: o_rdata <= {{(`PBMC_DATA_W-`PBMC_IRQ_W){1'b0}}, irq_stat_r};
          `PBMC_OFS_IRQ_MASK: o_rdata <= {{(`PBMC_DATA_W-`PBMC_IRQ_W){1'b0}}, irq_mask_r};
          default:            o_rdata <= `PBMC_RST_WORD;
        endcase
      end
    end
  end

  // ****************************************************************
  // Mode outputs and data path
  // ****************************************************************
  // Isolate and power down only gate the data path; the register port above
  // never looks at them, so management stays alive in both states.
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_speed_100      <= 1'b0;
      o_full_duplex    <= 1'b0;
      o_aneg_enable    <= 1'b0;
      o_aneg_restart   <= 1'b0;
      o_loopback       <= 1'b0;
      o_loop_dead      <= 1'b0;
      o_power_down     <= 1'b0;
      o_isolate        <= 1'b0;
      o_unidirectional <= 1'b0;
      o_core_reset     <= 1'b1;
      o_mac_rx_dv      <= 1'b0;
      o_mac_rxd        <= {NIB_W{1'b0}};
      o_mac_col        <= 1'b0;
      o_line_tx_en     <= 1'b0;
      o_line_txd       <= {NIB_W{1'b0}};
    end else if (i_ce) begin
      o_speed_100      <= aneg_r ? i_an_speed_100 : speed_r;
      o_full_duplex    <= aneg_r ? i_an_full_duplex : duplex_r;
      o_aneg_enable    <= aneg_r;
      o_aneg_restart   <= restart_r;
      o_loopback       <= loop_r;
      o_loop_dead      <= dead_cnt_r != {DEAD_W{1'b0}};
      o_power_down     <= pd_eff;
      o_isolate        <= iso_r;
      o_unidirectional <= unidir_r;
      o_core_reset     <= srst_busy_r;
      o_mac_col        <= colt_r & i_mac_tx_en & ~iso_r & ~pd_eff;
      o_line_tx_en     <= i_mac_tx_en & ~loop_r & ~iso_r & ~pd_eff;
      o_line_txd       <= (~loop_r & ~iso_r & ~pd_eff) ? i_mac_txd : {NIB_W{1'b0}};
      if (iso_r || pd_eff) begin
        o_mac_rx_dv <= 1'b0;
        o_mac_rxd   <= {NIB_W{1'b0}};
      end else if (loop_r) begin
        o_mac_rx_dv <= i_mac_tx_en & (dead_cnt_r == {DEAD_W{1'b0}});
        o_mac_rxd   <= i_mac_txd;
      end else begin
        o_mac_rx_dv <= i_line_rx_dv;
        o_mac_rxd   <= i_line_rxd;
      end
    end
  end

endmodule // pbmc_top

`default_nettype wire

// ===== pbmc_mac_model.sv
// Station-side MAC model that sends a counting nibble stream.
`timescale 1ns/100ps
`default_nettype none
module pbmc_mac_model (
  // Clock and transmit side
  input  wire logic       i_clk,
  output logic            o_tx_en,
  output logic [3:0]      o_txd
);
  // A counting pattern makes a looped or leaked nibble easy to spot.
  initial {o_tx_en, o_txd} = 5'h00;
  always @(posedge i_clk) {o_tx_en, o_txd} <= {o_tx_en, o_txd} + 5'h01;
endmodule // pbmc_mac_model
`default_nettype wire

// ===== pbmc_assertions.sv
// Port-level assertions for the mode control bank.
`timescale 1ns/100ps
`default_nettype none
module pbmc_assertions (
  // Watched ports of the bank
  input wire logic        i_clk, i_srst, i_wr, i_rd, i_power_down_pin_n,
  input wire logic [4:0]  i_addr,
  input wire logic [15:0] i_wdata, o_rdata,
  input wire logic        i_an_speed_100, i_an_full_duplex, o_speed_100, o_full_duplex,
  input wire logic        o_aneg_enable, o_loopback, o_loop_dead, o_power_down,
  input wire logic        o_isolate, o_core_reset, o_mac_rx_dv, o_line_tx_en
);
  // One clock domain, so clocking and reset are given once.
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  property p_rd_quiet; !$past(i_rd) |-> o_rdata == 16'h0000; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
  property p_srst_go; i_wr && i_addr == 5'h00 && i_wdata[15] |-> ##2 o_core_reset; endproperty
  a_srst_go: assert property (p_srst_go) else $error("soft reset not started");
  property p_srst_hold; $rose(o_core_reset) |-> o_core_reset[*8]; endproperty
  a_srst_hold: assert property (p_srst_hold) else $error("soft reset too short");
  property p_pin; (!i_power_down_pin_n)[*6] |-> o_power_down; endproperty
  a_pin: assert property (p_pin) else $error("pin did not power down");
  property p_iso; o_isolate[*2] |-> !o_mac_rx_dv && !o_line_tx_en; endproperty
  a_iso: assert property (p_iso) else $error("isolated port still moves data");
  property p_dead_rx; o_loop_dead |-> !o_mac_rx_dv; endproperty
  a_dead_rx: assert property (p_dead_rx) else $error("data during dead time");
  property p_loop_dead; $rose(o_loopback) |-> o_loop_dead; endproperty
  a_loop_dead: assert property (p_loop_dead) else $error("no dead time");
  property p_aneg;
    o_aneg_enable |-> o_speed_100 == $past(i_an_speed_100)
      && o_full_duplex == $past(i_an_full_duplex);
  endproperty
  a_aneg: assert property (p_aneg) else $error("negotiated mode ignored");
endmodule // pbmc_assertions
`default_nettype wire

// ===== phy_basic_mode_control_bench.sv
// Self-checking bench for the mode control bank.
`timescale 1ns/100ps
`default_nettype none
module phy_basic_mode_control_bench;
  logic i_clk = 0, i_srst = 1, i_wr = 0, i_rd = 0, rd_d = 0, ans = 0;
  logic pin_n = 1, s_an = 1, s_sp = 1, s_dup = 0, fib = 0, an_sp = 0, an_dup = 0;
  logic lnk = 1, flt = 0, rxe = 0, act = 0, rxdv = 0, tx_en, sp, dup, iso, irq, mdv, ltx, pd;
  logic [4:0] addr = 0;
  logic [15:0] wd = 0, o_rdata, eq[$], mq[$];
  logic [15:0] mv[4] = '{16'h2100, 16'h0000, 16'h2000, 16'h0500};
  logic [3:0] txd, mrxd, rxd = 0;
  int errors = 0, check_count = 0, seed = 32'hc86122f8;
  always #12.5 i_clk = ~i_clk;
  // Negotiation results and line data churn so stale values cannot pass.
  always @(posedge i_clk) {an_sp, an_dup, rxdv, rxd, ans} <= 8'($random(seed));
  pbmc_top #(.LOOP_DEAD_CYCLES(20)) i_pbmc_top (.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'b1),
    .i_addr(addr), .i_wdata(wd), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_power_down_pin_n(pin_n), .i_strap_aneg(s_an), .i_strap_speed_100(s_sp),
    .i_strap_full_duplex(s_dup), .i_fiber_mode_enable(fib), .i_an_speed_100(an_sp),
    .i_an_full_duplex(an_dup), .i_aneg_started(ans), .i_link_ok(lnk), .i_fault(flt),
    .i_rx_err(rxe), .i_event_active(act), .i_mac_tx_en(tx_en), .i_mac_txd(txd),
    .o_mac_rx_dv(mdv), .o_mac_rxd(mrxd), .o_mac_col(), .i_line_rx_dv(rxdv), .i_line_rxd(rxd),
    .o_line_tx_en(ltx), .o_line_txd(), .o_speed_100(sp), .o_full_duplex(dup),
    .o_aneg_enable(), .o_aneg_restart(), .o_loopback(), .o_loop_dead(), .o_power_down(pd),
    .o_isolate(iso), .o_unidirectional(), .o_core_reset(), .o_irq(irq));
  pbmc_mac_model i_pbmc_mac_model (.i_clk(i_clk), .o_tx_en(tx_en), .o_txd(txd));
  task automatic chk(input string n, input logic [15:0] s, e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk) begin addr <= a; wd <= d; i_wr <= 1; end
    @(posedge i_clk) i_wr <= 0;
  endtask
  // The expectation is queued before the strobe so the watcher never runs dry.
  task automatic rd(input logic [4:0] a, input logic [15:0] e, m);
    eq.push_back(e); mq.push_back(m);
    @(posedge i_clk) begin addr <= a; i_rd <= 1; end
    @(posedge i_clk) i_rd <= 0;
  endtask
  // Read data stand only in the cycle after the strobe, so compare there.
  always @(posedge i_clk) begin
    rd_d <= i_rd;
    if (rd_d) chk("rdata", o_rdata & mq.pop_front(), eq.pop_front());
  end
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin #(25 * 3000); errors++; summarize; end
  initial begin
    repeat (6) @(posedge i_clk);
    i_srst <= 0;
    repeat (90) @(posedge i_clk);
    rd(5'h00, 16'h3000, 16'hffff);
    rd(5'h03, 16'h0000, 16'hffff);
    wr(5'h00, 16'h407f);
    rd(5'h00, 16'h4020, 16'hffff);
    chk("dead", 16'({mdv, ltx}), 16'h0000);
    repeat (25) @(posedge i_clk);
    // The looped nibble is the one the MAC model sent a cycle earlier.
    chk("loop", 16'({mdv, mrxd, ltx}), 16'({5'({tx_en, txd} - 5'h01), 1'b0}));
    $display("defaults and loopback done");
    foreach (mv[i]) begin
      wr(5'h00, mv[i]);
      repeat (3) @(posedge i_clk);
      chk("mode", 16'({sp, dup, iso}), 16'({mv[i][13], mv[i][8], mv[i][10]}));
    end
    $display("forced modes done");
    @(posedge i_clk) begin act <= 1; flt <= 1; rxe <= 1; lnk <= 0; end
    @(posedge i_clk) begin flt <= 0; rxe <= 0; lnk <= 1; end
    rd(5'h14, 16'ha00e, 16'hffff);
    act <= 0;
    wr(5'h14, 16'hffff);
    rd(5'h14, 16'ha001, 16'hffff);
    $display("event bits done");
    @(posedge i_clk) pin_n <= 0;
    repeat (8) @(posedge i_clk);
    rd(5'h00, 16'h0800, 16'h0800);
    chk("pdown", 16'({pd, ltx}), 16'h0002);
    wr(5'h11, 16'h0004);
    rd(5'h10, 16'h0004, 16'h0004);
    chk("irq", 16'(irq), 16'h0001);
    wr(5'h10, 16'h001f);
    repeat (2) @(posedge i_clk);
    chk("irq", 16'(irq), 16'h0000);
    $display("power down pin done");
    @(posedge i_clk) begin pin_n <= 1; fib <= 1; end
    wr(5'h00, 16'h8000);
    rd(5'h00, 16'h8000, 16'h8000);
    repeat (90) @(posedge i_clk);
    rd(5'h00, 16'h2000, 16'hffff);
    repeat (3) @(posedge i_clk);
    $display("soft reset done");
    summarize;
  end
endmodule // phy_basic_mode_control_bench
bind pbmc_top pbmc_assertions i_pbmc_assertions (.*);
`default_nettype wire
